// File: design/sfmag_pkg.sv
// Constants, types and decode helpers for the register and memory access guard
//
// Behaviour
// RQ1 - Memory management configuration registers are reachable only in privileged mode.
// RQ2 - Privileged code may reach every hardware component register.
// RQ3 - Unprivileged code reaches only CPU registers by default; all else is denied.
// RQ4 - Component registers open to unprivileged code only when its grant bit is set.
// RQ5 - The segment table pointer changes only through privileged register writes.
// RQ6 - After reset every memory segment is disabled until software enables one.
// RQ7 - The firewall partition bounds are constants; no register or write alters them.
// RQ8 - Partition attributes reset to defaults; boot code writes them once, then locked.
// RQ9 - Software updates memory management attributes, subject to register privilege.
// RQ10 - Every register has a defined reset value and a fixed default permission.
// RQ11 - Access classes are fixed; only component grants for two modes are configurable.
// RQ12 - Denied accesses have no side effect and raise a one-cycle violation pulse.
package sfmag_pkg;

  // ----------------------------------------------------------------
  // CPU modes and register classes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_PRIV   = 2'h0,
    MODE_UNPRIV = 2'h1,
    MODE_FWAPP  = 2'h2
  } sfmag_mode_e;

  typedef enum logic [1:0] {
    CLS_CPU,
    CLS_MMU,
    CLS_RSVD,
    CLS_HW
  } sfmag_cls_e;

  // ----------------------------------------------------------------
  // Register address map (8-bit space)
  // ----------------------------------------------------------------
  localparam logic [7:0] CPU_FIRST      = 8'h80;
  localparam logic [7:0] MMU_FIRST      = 8'ha0;
  localparam logic [7:0] RSVD_FIRST     = 8'hb0;
  localparam logic [7:0] HW_FIRST       = 8'hc0;
  localparam int         HW_IDX_LSB     = 3;
  localparam int         HW_COUNT       = 8;

  localparam logic [7:0] ADDR_SEG_PTR_LO = 8'ha0;
  localparam logic [7:0] ADDR_SEG_PTR_HI = 8'ha1;
  localparam logic [7:0] ADDR_SEG_EN     = 8'ha2;
  localparam logic [7:0] ADDR_SEG_USER   = 8'ha3;
  localparam logic [7:0] ADDR_USER_GRANT = 8'ha4;
  localparam logic [7:0] ADDR_FWAP_GRANT = 8'ha5;
  localparam logic [7:0] ADDR_PART_ATTR  = 8'ha6;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_SEG_PTR    = 16'h0000;
  localparam logic [3:0]  RST_SEG_EN     = 4'h0;
  localparam logic [3:0]  RST_SEG_USER   = 4'h0;
  localparam logic [7:0]  RST_GRANT      = 8'h00;
  localparam logic [1:0]  RST_PART_ATTR  = 2'h0;
  localparam logic        RST_PART_LOCK  = 1'b0;

  // ----------------------------------------------------------------
  // Memory layout
  // ----------------------------------------------------------------
  localparam int          SEG_COUNT      = 4;
  localparam int          SEG_SEL_LSB    = 14;
  localparam logic [15:0] FW_BASE        = 16'hf000;
  localparam int          PART_PRIV_RD   = 0;
  localparam int          PART_PRIV_WR   = 1;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        valid;
    logic        write;
    sfmag_mode_e mode;
    logic [7:0]  addr;
    logic [7:0]  wdata;
  } sfmag_sfr_req_s;

  typedef struct packed {
    logic       valid;
    logic       granted;
    logic [7:0] rdata;
  } sfmag_sfr_rsp_s;

  typedef struct packed {
    logic        valid;
    logic        write;
    sfmag_mode_e mode;
    logic [15:0] addr;
  } sfmag_mem_req_s;

  typedef struct packed {
    logic [15:0] seg_ptr;
    logic [3:0]  seg_en;
    logic [3:0]  seg_user;
    logic [7:0]  user_grant;
    logic [7:0]  fwap_grant;
    logic [1:0]  part_attr;
    logic        part_lock;
  } sfmag_cfg_s;

  // ----------------------------------------------------------------
  // Address class decode
  // ----------------------------------------------------------------
  function automatic sfmag_cls_e sfmag_class(input logic [7:0] addr);
    sfmag_cls_e cls;
    cls = CLS_RSVD;
    if (addr >= HW_FIRST) begin
      cls = CLS_HW;
    end else if (addr >= RSVD_FIRST) begin
      cls = CLS_RSVD;
    end else if (addr >= MMU_FIRST) begin
      cls = CLS_MMU;
    end else if (addr >= CPU_FIRST) begin
      cls = CLS_CPU;
    end
    return cls;
  endfunction

endpackage

// File: design/sfmag_mem_check.sv
// Memory access permission check by segment, mode and firewall partition
`timescale 1ns/1ps
module sfmag_mem_check (
  input  wire sfmag_pkg::sfmag_mem_req_s mem_req,   // Memory request
  input  wire logic [3:0]                seg_en,    // Segment enables
  input  wire logic [3:0]                seg_user,  // Unprivileged segment rights
  input  wire logic [1:0]                part_attr, // Partition attributes
  output logic                           allow      // Access permitted
);

  logic [sfmag_pkg::SEG_COUNT-1:0] seg_hit;
  logic [sfmag_pkg::SEG_COUNT-1:0] seg_ok;
  logic                            in_part;
  logic                            part_ok;

  // ----------------------------------------------------------------
  // Per-segment rights
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < sfmag_pkg::SEG_COUNT; g++) begin : g_seg
      assign seg_hit[g] = (mem_req.addr[15:sfmag_pkg::SEG_SEL_LSB] == 2'(g));
      // Disabled segment refuses every mode
      assign seg_ok[g]  = seg_en[g] &&                                            // RQ6
                          ((mem_req.mode == sfmag_pkg::MODE_PRIV) ||
                           ((mem_req.mode == sfmag_pkg::MODE_UNPRIV) && seg_user[g]));
    end
  endgenerate

  // Partition bounds are constants, never software state
  assign in_part = (mem_req.addr >= sfmag_pkg::FW_BASE);                          // RQ7

  always_comb begin
    part_ok = 1'b0;
    unique case (mem_req.mode)
      sfmag_pkg::MODE_FWAPP: part_ok = 1'b1;
      sfmag_pkg::MODE_PRIV:  part_ok = mem_req.write ? part_attr[sfmag_pkg::PART_PRIV_WR]
                                                     : part_attr[sfmag_pkg::PART_PRIV_RD];
      default:               part_ok = 1'b0;
    endcase
  end

  // Firewall mode is confined to its partition
  assign allow = in_part ? part_ok : |(seg_hit & seg_ok);

endmodule

// File: design/sfmag_guard.sv
// Register and memory access guard: mode checks, configuration registers, violations
`timescale 1ns/1ps
module sfmag_guard (
  input  wire logic                      clk,            // System clock, 50 MHz
  input  wire logic                      srst,           // Synchronous reset, high
  input  wire sfmag_pkg::sfmag_sfr_req_s sfr_req,        // Register access from CPU
  output logic                           sfr_fwd_valid,  // Pass access to peripheral
  output sfmag_pkg::sfmag_sfr_rsp_s      sfr_rsp,        // Registered answer
  input  wire sfmag_pkg::sfmag_mem_req_s mem_req,        // Memory access from CPU
  output logic                           mem_grant,      // Memory access allowed
  output logic [15:0]                    seg_table_ptr,  // Segment table pointer
  output logic                           sfr_violation,  // Denied register access
  output logic                           mem_violation,  // Denied memory access
  output logic                           access_violation // Any denial, to exceptions
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  sfmag_pkg::sfmag_cfg_s     cfg_reg;
  sfmag_pkg::sfmag_cfg_s     cfg_next;
  sfmag_pkg::sfmag_sfr_rsp_s rsp_reg;
  sfmag_pkg::sfmag_sfr_rsp_s rsp_next;
  logic                      sfr_viol_reg;
  logic                      sfr_viol_next;
  logic                      mem_viol_reg;
  logic                      mem_viol_next;

  sfmag_pkg::sfmag_cls_e     req_cls;
  logic [2:0]                hw_idx;
  logic                      sfr_allow;
  logic                      mem_allow;
  logic                      mmu_write;
  logic [7:0]                mmu_rdata;

  // ----------------------------------------------------------------
  // Register permission decision
  // ----------------------------------------------------------------
  assign req_cls = sfmag_pkg::sfmag_class(sfr_req.addr);
  assign hw_idx  = sfr_req.addr[sfmag_pkg::HW_IDX_LSB +: 3];

  // Classes are wired; only the two grant masks change rights
  always_comb begin
    sfr_allow = 1'b0;
    unique case (sfr_req.mode)
      sfmag_pkg::MODE_PRIV: begin
        // Full reach including MMU and component registers
        sfr_allow = 1'b1;                                                         // RQ1 RQ2
      end
      sfmag_pkg::MODE_UNPRIV: begin
        sfr_allow = (req_cls == sfmag_pkg::CLS_CPU) ||                            // RQ3
                    ((req_cls == sfmag_pkg::CLS_HW) &&
                     cfg_reg.user_grant[hw_idx]);                                 // RQ4 RQ11
      end
      sfmag_pkg::MODE_FWAPP: begin
        sfr_allow = (req_cls == sfmag_pkg::CLS_CPU) ||
                    ((req_cls == sfmag_pkg::CLS_HW) &&
                     cfg_reg.fwap_grant[hw_idx]);                                 // RQ11
      end
      default: begin
        // Undefined mode code is treated as hostile
        sfr_allow = 1'b0;
      end
    endcase
  end

  // Peripherals see only allowed accesses outside this block
  assign sfr_fwd_valid = sfr_req.valid && sfr_allow &&                            // RQ12
                         (sfmag_pkg::sfmag_class(sfr_req.addr) != sfmag_pkg::CLS_MMU) &&
                         (sfmag_pkg::sfmag_class(sfr_req.addr) != sfmag_pkg::CLS_RSVD);

  assign mmu_write = sfr_req.valid && sfr_req.write && sfr_allow &&
                     (req_cls == sfmag_pkg::CLS_MMU);

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  always_comb begin
    cfg_next = cfg_reg;
    if (mmu_write) begin
      unique case (sfr_req.addr)
        sfmag_pkg::ADDR_SEG_PTR_LO: begin
          cfg_next.seg_ptr[7:0] = sfr_req.wdata;                                  // RQ5
        end
        sfmag_pkg::ADDR_SEG_PTR_HI: begin
          cfg_next.seg_ptr[15:8] = sfr_req.wdata;                                 // RQ5
        end
        sfmag_pkg::ADDR_SEG_EN: begin
          cfg_next.seg_en = sfr_req.wdata[3:0];                                   // RQ9
        end
        sfmag_pkg::ADDR_SEG_USER: begin
          cfg_next.seg_user = sfr_req.wdata[3:0];                                 // RQ9
        end
        sfmag_pkg::ADDR_USER_GRANT: begin
          cfg_next.user_grant = sfr_req.wdata;                                    // RQ4
        end
        sfmag_pkg::ADDR_FWAP_GRANT: begin
          cfg_next.fwap_grant = sfr_req.wdata;                                    // RQ11
        end
        sfmag_pkg::ADDR_PART_ATTR: begin
          // Boot code gets one shot; later writes are dropped silently
          if (!cfg_reg.part_lock) begin
            cfg_next.part_attr = sfr_req.wdata[1:0];                              // RQ8
            cfg_next.part_lock = 1'b1;                                            // RQ8
          end
        end
        default: begin
          cfg_next = cfg_reg;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cfg_reg.seg_ptr    <= sfmag_pkg::RST_SEG_PTR;                               // RQ10
      cfg_reg.seg_en     <= sfmag_pkg::RST_SEG_EN;                                // RQ6
      cfg_reg.seg_user   <= sfmag_pkg::RST_SEG_USER;                              // RQ6
      cfg_reg.user_grant <= sfmag_pkg::RST_GRANT;                                 // RQ10
      cfg_reg.fwap_grant <= sfmag_pkg::RST_GRANT;                                 // RQ10
      cfg_reg.part_attr  <= sfmag_pkg::RST_PART_ATTR;                             // RQ8
      cfg_reg.part_lock  <= sfmag_pkg::RST_PART_LOCK;                             // RQ8
    end else begin
      cfg_reg <= cfg_next;
    end
  end

  assign seg_table_ptr = cfg_reg.seg_ptr;

  // ----------------------------------------------------------------
  // Read answer
  // ----------------------------------------------------------------
  always_comb begin
    mmu_rdata = 8'h00;
    unique case (sfr_req.addr)
      sfmag_pkg::ADDR_SEG_PTR_LO: mmu_rdata = cfg_reg.seg_ptr[7:0];
      sfmag_pkg::ADDR_SEG_PTR_HI: mmu_rdata = cfg_reg.seg_ptr[15:8];
      sfmag_pkg::ADDR_SEG_EN:     mmu_rdata = {4'h0, cfg_reg.seg_en};
      sfmag_pkg::ADDR_SEG_USER:   mmu_rdata = {4'h0, cfg_reg.seg_user};
      sfmag_pkg::ADDR_USER_GRANT: mmu_rdata = cfg_reg.user_grant;
      sfmag_pkg::ADDR_FWAP_GRANT: mmu_rdata = cfg_reg.fwap_grant;
      sfmag_pkg::ADDR_PART_ATTR:  mmu_rdata = {5'h00, cfg_reg.part_lock, cfg_reg.part_attr};
      default:                    mmu_rdata = 8'h00;
    endcase
  end

  always_comb begin
    rsp_next         = '0;
    rsp_next.valid   = sfr_req.valid;
    rsp_next.granted = sfr_req.valid && sfr_allow;
    // Denied reads return zero so no secret leaks
    if (sfr_req.valid && !sfr_req.write && sfr_allow &&
        (req_cls == sfmag_pkg::CLS_MMU)) begin
      rsp_next.rdata = mmu_rdata;                                                 // RQ1
    end
  end

  // ----------------------------------------------------------------
  // Memory path
  // ----------------------------------------------------------------
  sfmag_mem_check u_mem_check (
    .mem_req   (mem_req),
    .seg_en    (cfg_reg.seg_en),
    .seg_user  (cfg_reg.seg_user),
    .part_attr (cfg_reg.part_attr),
    .allow     (mem_allow)
  );

  // Combinational so the CPU is stopped in the same cycle
  assign mem_grant = mem_req.valid && mem_allow;                                  // RQ6 RQ7

  // ----------------------------------------------------------------
  // Violation events
  // ----------------------------------------------------------------
  always_comb begin
    sfr_viol_next = sfr_req.valid && !sfr_allow;                                  // RQ12
    mem_viol_next = mem_req.valid && !mem_allow;                                  // RQ12
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rsp_reg      <= '0;
      sfr_viol_reg <= 1'b0;
      mem_viol_reg <= 1'b0;
    end else begin
      rsp_reg      <= rsp_next;
      sfr_viol_reg <= sfr_viol_next;
      mem_viol_reg <= mem_viol_next;
    end
  end

  assign sfr_rsp          = rsp_reg;
  assign sfr_violation    = sfr_viol_reg;
  assign mem_violation    = mem_viol_reg;
  assign access_violation = sfr_viol_reg || mem_viol_reg;

endmodule

// File: testbench/sfmag_guard_assertions.sv
// Checker for port timing and permission relations of the access guard
`timescale 1ns/1ps
module sfmag_guard_chk (
  input wire logic                      clk,             // System clock
  input wire logic                      srst,            // Synchronous reset, high
  input wire sfmag_pkg::sfmag_sfr_req_s sfr_req,         // Register access
  input wire logic                      sfr_fwd_valid,   // Forward strobe
  input wire sfmag_pkg::sfmag_sfr_rsp_s sfr_rsp,         // Registered answer
  input wire sfmag_pkg::sfmag_mem_req_s mem_req,         // Memory access
  input wire logic                      mem_grant,       // Memory allowed
  input wire logic [15:0]               seg_table_ptr,   // Segment table pointer
  input wire logic                      sfr_violation,   // Register denial
  input wire logic                      mem_violation,   // Memory denial
  input wire logic                      access_violation // Any denial
);
  logic up;
  logic uf;
  assign up = sfr_req.mode != sfmag_pkg::MODE_PRIV;
  assign uf = sfr_req.mode inside {sfmag_pkg::MODE_UNPRIV, sfmag_pkg::MODE_FWAPP};
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  a_deny_flagged: assert property (
    sfr_req.valid |=> sfr_rsp.valid && sfr_violation == !sfr_rsp.granted)
    else $error("register answer or denial flag wrong");
  a_deny_silent: assert property (
    sfr_req.valid |=> sfr_rsp.granted || sfr_rsp.rdata == 8'h00)
    else $error("denied access returned data");
  a_mmu_priv_only: assert property (
    sfr_req.valid && up && sfr_req.addr[7:4] == 4'ha |=> !sfr_rsp.granted)
    else $error("configuration register open outside privileged mode");
  a_priv_hw_open: assert property (
    sfr_req.valid && !up && sfr_req.addr >= sfmag_pkg::HW_FIRST |-> sfr_fwd_valid)
    else $error("privileged component access not forwarded");
  a_cpu_regs_open: assert property (
    sfr_req.valid && uf && sfr_req.addr[7:5] == 3'h4 |-> sfr_fwd_valid)
    else $error("core register closed to unprivileged code");
  a_rsvd_closed: assert property (
    sfr_req.valid && up && (sfr_req.addr < 8'h80 || sfr_req.addr[7:4] == 4'hb)
    |-> !sfr_fwd_valid ##1 sfr_violation)
    else $error("reserved register reachable without privilege");
  a_ptr_guarded: assert property (
    !(sfr_req.valid && sfr_req.write && !up && sfr_req.addr[7:1] == 7'h50)
    |=> $stable(seg_table_ptr))
    else $error("table pointer moved without privileged write");
  a_fw_fixed: assert property (
    mem_req.valid && mem_req.mode == sfmag_pkg::MODE_UNPRIV && mem_req.addr >= 16'hf000
    |-> !mem_grant ##1 mem_violation)
    else $error("partition open to unprivileged code");
  a_fw_app_in: assert property (
    mem_req.valid && mem_req.mode == sfmag_pkg::MODE_FWAPP && mem_req.addr >= 16'hf000
    |-> mem_grant)
    else $error("partition closed to firewall application");
  a_mem_deny_flag: assert property (
    mem_req.valid && !mem_grant |=> mem_violation)
    else $error("memory denial not flagged");
  a_viol_merge: assert property (
    access_violation == (sfr_violation || mem_violation))
    else $error("merged violation does not match sources");
  c_sfr_deny: cover property (sfr_violation);
  c_fw_grant: cover property (mem_grant && mem_req.mode == sfmag_pkg::MODE_FWAPP);
  c_hw_user: cover property (sfr_fwd_valid && up && sfr_req.addr >= 8'hc0);
endmodule

bind sfmag_guard sfmag_guard_chk i_chk (.clk, .srst, .sfr_req, .sfr_fwd_valid, .sfr_rsp,
  .mem_req, .mem_grant, .seg_table_ptr, .sfr_violation, .mem_violation, .access_violation);

// File: testbench/sfmag_cpu_model.sv
// Behavioural CPU core issuing mode-tagged register and memory accesses
`timescale 1ns/1ps
module sfmag_cpu_model (
  input  wire logic                 clk,           // System clock
  input  wire logic                 sfr_fwd_valid, // Forward strobe from guard
  input  wire logic                 mem_grant,     // Memory grant from guard
  output sfmag_pkg::sfmag_sfr_req_s sfr_req,       // Register access
  output sfmag_pkg::sfmag_mem_req_s mem_req        // Memory access
);
  initial begin
    sfr_req = '0;
    mem_req = '0;
  end
  // On release valid drops and write, address and data invert while mode is kept, so a stale value never looks like a request
  task automatic special_function_register(input logic w, input sfmag_pkg::sfmag_mode_e m, input logic [7:0] a,
                     input logic [7:0] d, output logic fwd);
    @(posedge clk);
    #1 sfr_req = '{1'b1, w, m, a, d};
    #5 fwd = sfr_fwd_valid;
    @(posedge clk);
    #1 sfr_req = '{1'b0, ~w, m, ~a, ~d};
  endtask
  task automatic mem(input logic w, input sfmag_pkg::sfmag_mode_e m, input logic [15:0] a,
                     output logic g);
    @(posedge clk);
    #1 mem_req = '{1'b1, w, m, a};
    #5 g = mem_grant;
    @(posedge clk);
    #1 mem_req = '{1'b0, ~w, m, ~a};
  endtask
endmodule

// File: testbench/tb.sv
// Self-checking testbench for the register and memory access guard
`timescale 1ns/1ps
module tb;
  localparam sfmag_pkg::sfmag_mode_e priv   = sfmag_pkg::MODE_PRIV;
  localparam sfmag_pkg::sfmag_mode_e unpriv = sfmag_pkg::MODE_UNPRIV;
  localparam sfmag_pkg::sfmag_mode_e fwapp  = sfmag_pkg::MODE_FWAPP;
  localparam sfmag_pkg::sfmag_mode_e undef  = sfmag_pkg::sfmag_mode_e'(2'h3);
  logic                      clk = 1'b0;
  logic                      srst = 1'b1;
  sfmag_pkg::sfmag_sfr_req_s sfr_req;
  sfmag_pkg::sfmag_sfr_rsp_s sfr_rsp;
  sfmag_pkg::sfmag_mem_req_s mem_req;
  logic                      sfr_fwd_valid;
  logic                      mem_grant;
  logic [15:0]               seg_table_ptr;
  logic                      sfr_violation;
  logic                      mem_violation;
  logic                      access_violation;
  int                        failures = 0;
  int                        tests_run = 0;

  always #10 clk = ~clk;

  sfmag_cpu_model i_cpu (.clk(clk), .sfr_fwd_valid(sfr_fwd_valid), .mem_grant(mem_grant),
                         .sfr_req(sfr_req), .mem_req(mem_req));
  sfmag_guard i_dut (.clk(clk), .srst(srst), .sfr_req(sfr_req), .sfr_fwd_valid(sfr_fwd_valid),
                     .sfr_rsp(sfr_rsp), .mem_req(mem_req), .mem_grant(mem_grant),
                     .seg_table_ptr(seg_table_ptr), .sfr_violation(sfr_violation),
                     .mem_violation(mem_violation), .access_violation(access_violation));

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", n, e, g);
    end
  endtask
  task automatic acc(input logic w, input sfmag_pkg::sfmag_mode_e m, input logic [7:0] a,
                     input logic [7:0] d, input logic g, input logic f, input logic [7:0] r);
    logic fwd;
    i_cpu.special_function_register(w, m, a, d, fwd);
    chk("forward", {15'h0, f}, {15'h0, fwd});
    chk("answer", {14'h0, g, 1'b1}, {14'h0, sfr_rsp.granted, sfr_rsp.valid});
    chk("violation", {14'h0, ~g, ~g}, {14'h0, sfr_violation, access_violation});
    if (!w) chk("read data", {8'h0, r}, {8'h0, sfr_rsp.rdata});
  endtask
  task automatic macc(input logic w, input sfmag_pkg::sfmag_mode_e m, input logic [15:0] a,
                      input logic g);
    logic gr;
    i_cpu.mem(w, m, a, gr);
    chk("grant", {15'h0, g}, {15'h0, gr});
    chk("mem violation", {14'h0, ~g, ~g}, {14'h0, mem_violation, access_violation});
  endtask

  task automatic t_defaults;
    chk("table pointer", 16'h0000, seg_table_ptr);
    for (int i = 0; i < 7; i++) begin
      acc(1'b0, priv, 8'ha0 + 8'(i), 8'h00, 1'b1, 1'b0, 8'h00);
    end
    for (int i = 0; i < 4; i++) begin
      macc(1'b0, priv, {2'(i), 14'h0}, 1'b0);
    end
  endtask
  task automatic t_mmu_priv;
    acc(1'b1, unpriv, sfmag_pkg::ADDR_SEG_PTR_LO, 8'h5a, 1'b0, 1'b0, 8'h00);
    acc(1'b1, fwapp, sfmag_pkg::ADDR_SEG_PTR_HI, 8'ha5, 1'b0, 1'b0, 8'h00);
    chk("table pointer", 16'h0000, seg_table_ptr);
    acc(1'b0, unpriv, sfmag_pkg::ADDR_SEG_EN, 8'h00, 1'b0, 1'b0, 8'h00);
    acc(1'b1, priv, sfmag_pkg::ADDR_SEG_PTR_LO, 8'h34, 1'b1, 1'b0, 8'h00);
    acc(1'b1, priv, sfmag_pkg::ADDR_SEG_PTR_HI, 8'h12, 1'b1, 1'b0, 8'h00);
    chk("table pointer", 16'h1234, seg_table_ptr);
    acc(1'b0, priv, sfmag_pkg::ADDR_SEG_PTR_HI, 8'h00, 1'b1, 1'b0, 8'h12);
    acc(1'b1, priv, 8'ha7, 8'h55, 1'b1, 1'b0, 8'h00);
    acc(1'b0, priv, 8'ha7, 8'h00, 1'b1, 1'b0, 8'h00);
    chk("table pointer", 16'h1234, seg_table_ptr);
  endtask
  task automatic t_grants;
    acc(1'b0, unpriv, 8'hc8, 8'h00, 1'b0, 1'b0, 8'h00);
    acc(1'b0, priv, 8'hc8, 8'h00, 1'b1, 1'b1, 8'h00);
    acc(1'b1, unpriv, 8'h9f, 8'h3c, 1'b1, 1'b1, 8'h00);
    acc(1'b0, unpriv, 8'hb0, 8'h00, 1'b0, 1'b0, 8'h00);
    acc(1'b1, priv, 8'hb4, 8'h77, 1'b1, 1'b0, 8'h00);
    acc(1'b0, fwapp, 8'h7f, 8'h00, 1'b0, 1'b0, 8'h00);
    acc(1'b1, unpriv, sfmag_pkg::ADDR_USER_GRANT, 8'h02, 1'b0, 1'b0, 8'h00);
    acc(1'b1, priv, sfmag_pkg::ADDR_USER_GRANT, 8'h02, 1'b1, 1'b0, 8'h00);
    acc(1'b1, unpriv, 8'hcf, 8'h11, 1'b1, 1'b1, 8'h00);
    acc(1'b0, unpriv, 8'hd0, 8'h00, 1'b0, 1'b0, 8'h00);
    acc(1'b0, fwapp, 8'hc8, 8'h00, 1'b0, 1'b0, 8'h00);
    acc(1'b1, priv, sfmag_pkg::ADDR_FWAP_GRANT, 8'h80, 1'b1, 1'b0, 8'h00);
    acc(1'b0, fwapp, 8'hf8, 8'h00, 1'b1, 1'b1, 8'h00);
  endtask
  task automatic t_segments;
    acc(1'b1, priv, sfmag_pkg::ADDR_SEG_EN, 8'h01, 1'b1, 1'b0, 8'h00);
    macc(1'b0, priv, 16'h3fff, 1'b1);
    macc(1'b1, unpriv, 16'h0000, 1'b0);
    macc(1'b1, priv, 16'h4000, 1'b0);
    acc(1'b1, priv, sfmag_pkg::ADDR_SEG_USER, 8'h01, 1'b1, 1'b0, 8'h00);
    macc(1'b1, unpriv, 16'h0010, 1'b1);
    acc(1'b0, undef, 8'h80, 8'h00, 1'b0, 1'b0, 8'h00);
    macc(1'b0, undef, 16'h0010, 1'b0);
  endtask
  task automatic t_partition;
    macc(1'b0, priv, sfmag_pkg::FW_BASE, 1'b0);
    macc(1'b1, fwapp, 16'hffff, 1'b1);
    macc(1'b0, fwapp, 16'h0000, 1'b0);
    macc(1'b0, unpriv, 16'hf800, 1'b0);
    acc(1'b1, priv, sfmag_pkg::ADDR_PART_ATTR, 8'h01, 1'b1, 1'b0, 8'h00);
    macc(1'b0, priv, 16'hf000, 1'b1);
    macc(1'b1, priv, 16'hf000, 1'b0);
    acc(1'b1, priv, sfmag_pkg::ADDR_PART_ATTR, 8'h03, 1'b1, 1'b0, 8'h00);
    macc(1'b1, priv, 16'hf000, 1'b0);
    acc(1'b0, priv, sfmag_pkg::ADDR_PART_ATTR, 8'h00, 1'b1, 1'b0, 8'h05);
  endtask
  // Mid-run reset must drop every setting, the partition lock included
  task automatic t_rerun_reset;
    @(posedge clk);
    #1 srst = 1'b1;
    @(posedge clk);
    #1 srst = 1'b0;
    chk("table pointer", 16'h0000, seg_table_ptr);
    macc(1'b0, priv, 16'h0000, 1'b0);
    acc(1'b0, priv, sfmag_pkg::ADDR_PART_ATTR, 8'h00, 1'b1, 1'b0, 8'h00);
  endtask

  task automatic results;
    $display("Comparisons %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge clk);
    #1 srst = 1'b0;
    t_defaults();
    t_mmu_priv();
    t_grants();
    t_segments();
    t_partition();
    t_rerun_reset();
    results();
  end
  // About 115 cycles of traffic; the limit leaves wide margin
  initial begin
    #100000;
    failures++;
    results();
  end
endmodule
